// >>> rtl/eba_map.vh
// Register offsets, field positions and timing constants of the EEPROM byte access port
`ifndef EBA_MAP_VH
`define EBA_MAP_VH
// ****************************************
// I/O space offsets (chosen; no offsets given)
// ****************************************
`define EBA_OFS_CTRL 6'h1f
`define EBA_OFS_DATA 6'h20
`define EBA_OFS_ADDR_LO 6'h21
`define EBA_OFS_ADDR_HI 6'h22
// ****************************************
// Control register fields
// ****************************************
`define EBA_BIT_READ 0
`define EBA_BIT_STROBE 1
`define EBA_BIT_ARM 2
`define EBA_BIT_MODE_LO 4
`define EBA_BIT_MODE_HI 5
`define EBA_MODE_RESET 2'h0
`define EBA_MODE_ERASE_WRITE 2'h0
`define EBA_MODE_ERASE 2'h1
`define EBA_MODE_WRITE 2'h2
`define EBA_MODE_RSVD 2'h3
// ****************************************
// Timing
// ****************************************
`define EBA_READ_HALT 3'h4
`define EBA_WRITE_HALT 3'h2
`define EBA_ARM_CYCLES 3'h4
`define EBA_ADDR_BITS 9
// Programming times in microseconds
`define EBA_T_ATOMIC_US 3400
`define EBA_T_SPLIT_US 1800
`define EBA_CLK_MHZ 200
`endif

// >>> rtl/eba_port.v
// EEPROM byte access port: I/O registers, protected write, stall and write timing
//
// Behaviour
// - A read strobe stalls the CPU for four cycles.
// - A write start stalls the CPU for two cycles.
// - EEPROM is a separate byte space of 256 or 512 bytes.
// - Byte address is linear, from a 9-bit address field.
// - Address bits 15 to 9 read as zero.
// - Data register holds write data, and read data after a read.
// - Address, data and control registers live in I/O space.
// - Writes self-time; the strobe bit shows when the next may start.
// - A write happens only via the armed sequence.
// - Arm clears after four cycles; strobe ignored while arm is clear.
// - Strobe stays set while programming, cleared by hardware after.
// - Mode 00 erase+write, 01 erase, 10 write; locked while busy.
// - Read loads data at once; reads and address writes blocked while busy.
`timescale 1ns/100ps
`include "eba_map.vh"

module eba_port #(
  parameter DEPTH = 512,
  parameter T_ATOMIC_CYC = `EBA_T_ATOMIC_US * `EBA_CLK_MHZ,
  parameter T_SPLIT_CYC = `EBA_T_SPLIT_US * `EBA_CLK_MHZ
) (
  input wire clk,
  input wire sys_rst,
  // CPU I/O bus, same clock as the core, so no synchroniser
  input wire [5:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  // Answers and status back to the core
  output reg [7:0] io_rdata,
  output reg cpu_stall,
  output reg write_busy
);

  // ****************************************
  // Local constants
  // ****************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_ERASE = 3'b010;
  localparam ST_PROG = 3'b100;
  localparam AW = `EBA_ADDR_BITS;
  // The edge that raises the stall also loads the counter, so the counter
  // only has to cover the halted cycles that remain after the first one
  localparam [2:0] RD_HALT_LOAD = `EBA_READ_HALT - 3'h1;
  localparam [2:0] WR_HALT_LOAD = `EBA_WRITE_HALT - 3'h1;

  // ****************************************
  // Storage and registers
  // ****************************************
  // Cell array; its contents are not touched by reset, like the real array
  reg [7:0] mem [0:DEPTH-1];
  reg [AW-1:0] eeprom_byte_address_r;
  reg [7:0] eeprom_data_byte_r;
  reg [1:0] program_mode_field_r;
  reg write_arm_bit_r;
  reg write_strobe_bit_r;
  reg [2:0] arm_cnt_r;
  reg [2:0] halt_cnt_r;
  reg [2:0] state_r;
  reg [23:0] prog_cnt_r;
  // Snapshot of the write request, held for the whole cell operation
  reg [AW-1:0] prog_addr_r;
  reg [7:0] prog_data_r;

  // ****************************************
  // Register decode
  // ****************************************
  // One-hot select shared by the write strobes and the read mux, so both
  // sides always agree on which offset belongs to which register
  function [3:0] reg_sel;
    input [5:0] addr;
    begin
      if (addr == `EBA_OFS_CTRL) begin
        reg_sel = 4'h1;
      end else if (addr == `EBA_OFS_DATA) begin
        reg_sel = 4'h2;
      end else if (addr == `EBA_OFS_ADDR_LO) begin
        reg_sel = 4'h4;
      end else if (addr == `EBA_OFS_ADDR_HI) begin
        reg_sel = 4'h8;
      end else begin
        reg_sel = 4'h0;
      end
    end
  endfunction

  wire [3:0] wr_sel = io_wr ? reg_sel(io_addr) : 4'h0;
  wire [3:0] rd_sel = io_rd ? reg_sel(io_addr) : 4'h0;
  wire wr_ctrl = wr_sel[0];
  wire wr_data = wr_sel[1];
  wire wr_alo = wr_sel[2];
  wire wr_ahi = wr_sel[3];

  // ****************************************
  // Access qualification
  // ****************************************
  // The strobe bit doubles as the busy flag: while it is set the engine owns
  // address and mode, and every request that could disturb them is dropped
  wire busy = write_strobe_bit_r;
  wire ctrl_strobe = wr_ctrl && io_wdata[`EBA_BIT_STROBE];
  wire ctrl_read = wr_ctrl && io_wdata[`EBA_BIT_READ];
  wire ctrl_arm = wr_ctrl && io_wdata[`EBA_BIT_ARM] && !io_wdata[`EBA_BIT_STROBE];
  wire mode_legal = (program_mode_field_r != `EBA_MODE_RSVD);
  // A strobe outside the arm window is dropped silently; software sees the
  // strobe bit stay clear and knows that the write did not start
  wire start_wr = ctrl_strobe && write_arm_bit_r && !busy && mode_legal;
  // A write start wins over a read asked for in the same control write
  wire start_rd = ctrl_read && !busy && !start_wr;
  // On the small variant the address msb is forced low whatever was written
  wire [AW-1:0] eff_addr = (DEPTH <= 256) ? {1'b0, eeprom_byte_address_r[AW-2:0]}
                                          : eeprom_byte_address_r;

  // Erase-only and write-only share the split time; reserved never starts
  function [23:0] prog_time;
    input [1:0] mode;
    begin
      if (mode == `EBA_MODE_ERASE_WRITE)
        prog_time = T_ATOMIC_CYC[23:0];
      else
        prog_time = T_SPLIT_CYC[23:0];
    end
  endfunction

  // Saturates at zero so a stray decrement can never wrap into a long window
  function [2:0] dec3;
    input [2:0] v;
    begin
      if (v == 3'h0) begin
        dec3 = 3'h0;
      end else begin
        dec3 = v - 3'h1;
      end
    end
  endfunction

  // ****************************************
  // Address and data registers
  // ****************************************
  // Address comes up undefined in the real part; cleared here only for clean simulation
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      eeprom_byte_address_r <= {AW{1'b0}};
    end else begin
      if (wr_alo && !busy) begin
        eeprom_byte_address_r[7:0] <= io_wdata;
      end
      if (wr_ahi && !busy) begin
        eeprom_byte_address_r[AW-1] <= io_wdata[0];
      end
    end
  end

  // Data may be reloaded while a write runs, since the engine holds its own
  // copy; a read and a data write can never meet in one cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      eeprom_data_byte_r <= 8'h00;
    end else if (start_rd) begin
      eeprom_data_byte_r <= mem[eff_addr];
    end else if (wr_data) begin
      eeprom_data_byte_r <= io_wdata;
    end
  end

  // ****************************************
  // Control register arm window
  // ****************************************
  // The window counts from the arm write itself: a strobe on the fourth
  // edge after it is still taken, one on the fifth is not
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_arm_bit_r <= 1'b0;
      arm_cnt_r <= 3'h0;
    end else begin
      if (start_wr) begin
        write_arm_bit_r <= 1'b0;
      end else if (ctrl_arm) begin
        write_arm_bit_r <= 1'b1;
        arm_cnt_r <= `EBA_ARM_CYCLES;
      end else if (write_arm_bit_r) begin
        arm_cnt_r <= dec3(arm_cnt_r);
        if (arm_cnt_r == 3'h1) begin
          write_arm_bit_r <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Programming mode
  // ****************************************
  // Locked while the strobe is set; reset also stops the engine, so a reset
  // never leaves a half-done cell operation running with a changed mode
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      program_mode_field_r <= `EBA_MODE_RESET;
    end else if (wr_ctrl && !busy) begin
      program_mode_field_r <= io_wdata[`EBA_BIT_MODE_HI:`EBA_BIT_MODE_LO];
    end
  end

  // ****************************************
  // Self-timed programming engine
  // ****************************************
  // Erase leaves a byte at all ones and programming can only clear bits,
  // so an atomic write yields the new data and a write-only ANDs it in
  wire prog_last = (prog_cnt_r <= 24'h000001);
  wire keep_cell = (program_mode_field_r == `EBA_MODE_ERASE);
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      write_strobe_bit_r <= 1'b0;
      prog_cnt_r <= 24'h000000;
      prog_addr_r <= {AW{1'b0}};
      prog_data_r <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_wr) begin
            write_strobe_bit_r <= 1'b1;
            prog_cnt_r <= prog_time(program_mode_field_r);
            prog_addr_r <= eff_addr;
            prog_data_r <= eeprom_data_byte_r;
            // Write-only skips the erase step
            state_r <= (program_mode_field_r == `EBA_MODE_WRITE) ? ST_PROG : ST_ERASE;
          end
        end
        ST_ERASE: begin
          mem[prog_addr_r] <= 8'hff;
          state_r <= ST_PROG;
        end
        ST_PROG: begin
          if (prog_last) begin
            if (!keep_cell) begin
              mem[prog_addr_r] <= mem[prog_addr_r] & prog_data_r;
            end
            write_strobe_bit_r <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            prog_cnt_r <= prog_cnt_r - 24'h000001;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // CPU stall
  // ****************************************
  // Stall rises the cycle after the trigger and holds for exactly the halt count
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      halt_cnt_r <= 3'h0;
      cpu_stall <= 1'b0;
    end else if (start_rd) begin
      halt_cnt_r <= RD_HALT_LOAD;
      cpu_stall <= 1'b1;
    end else if (start_wr) begin
      halt_cnt_r <= WR_HALT_LOAD;
      cpu_stall <= 1'b1;
    end else if (halt_cnt_r != 3'h0) begin
      halt_cnt_r <= dec3(halt_cnt_r);
    end else begin
      cpu_stall <= 1'b0;
    end
  end

  // ****************************************
  // I/O read port
  // ****************************************
  // Idle and unmapped reads return zero so the core can OR several
  // peripherals onto its data bus without a separate enable
  reg [7:0] io_rdata_nxt;
  always @* begin
    io_rdata_nxt = 8'h00;
    if (rd_sel[0]) begin
      io_rdata_nxt = {2'b00, program_mode_field_r, 1'b0, write_arm_bit_r,
                      write_strobe_bit_r, 1'b0};
    end else if (rd_sel[1]) begin
      io_rdata_nxt = eeprom_data_byte_r;
    end else if (rd_sel[2]) begin
      io_rdata_nxt = eeprom_byte_address_r[7:0];
    end else if (rd_sel[3]) begin
      io_rdata_nxt = {7'h00, eeprom_byte_address_r[AW-1]};
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_rdata <= 8'h00;
      write_busy <= 1'b0;
    end else begin
      io_rdata <= io_rdata_nxt;
      write_busy <= write_strobe_bit_r;
    end
  end

endmodule // eba_port

// >>> tb/eba_port_properties.sv
// Assertion checker for the EEPROM byte access port
`timescale 1ns/100ps
`include "eba_map.vh"
module eba_chk #(
  parameter T_ATOMIC_CYC = 20,
  parameter T_SPLIT_CYC = 10
) (
  input wire clk,
  input wire sys_rst,
  input wire [5:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire cpu_stall,
  input wire write_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  reg [2:0] arm_r;
  reg [1:0] mode_r;
  reg [31:0] len_r;
  wire ctl = io_wr && io_addr == `EBA_OFS_CTRL;
  wire ok = arm_r != 3'h0 && arm_r < 3'h5 && io_wdata[5:4] != 2'h3;
  wire st = ctl && io_wdata[1:0] == 2'h2 && !cpu_stall && !write_busy;
  wire [31:0] tw = mode_r == 2'h0 ? T_ATOMIC_CYC : T_SPLIT_CYC;
  // Age of the arm bit saturates so a late strobe stays recognisable
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arm_r <= 3'h0;
      mode_r <= 2'h0;
      len_r <= 32'h0;
    end else begin
      if (ctl && io_wdata[2:1] == 2'h2)
        arm_r <= 3'h1;
      else if (arm_r != 3'h0 && arm_r != 3'h7)
        arm_r <= arm_r + 3'h1;
      if (st && ok)
        mode_r <= io_wdata[5:4];
      len_r <= write_busy ? len_r + 32'h1 : 32'h0;
    end
  end
  sequence s_rd4; cpu_stall [*4] ##1 !cpu_stall; endsequence
  sequence s_wr2; cpu_stall [*2] ##1 !cpu_stall; endsequence
  property p_rd; ctl && io_wdata[1:0] == 2'h1 && !cpu_stall && !write_busy |=> s_rd4; endproperty
  a_rd: assert property (p_rd) else $error("read stall");
  property p_wr; st && ok |=> s_wr2; endproperty
  a_wr: assert property (p_wr) else $error("write stall");
  property p_no; st && !ok |=> !cpu_stall; endproperty
  a_no: assert property (p_no) else $error("strobe taken");
  property p_bz; st && ok |-> ##[1:3] write_busy; endproperty
  a_bz: assert property (p_bz) else $error("no busy");
  property p_len; $fell(write_busy) |-> len_r + 32'h1 >= tw && len_r <= tw + 32'h1; endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_map; io_rd && io_addr > `EBA_OFS_ADDR_HI |=> io_rdata == 8'h00; endproperty
  a_map: assert property (p_map) else $error("unmapped read");
  property p_hi; io_rd && io_addr == `EBA_OFS_ADDR_HI |=> io_rdata[7:1] == 7'h00; endproperty
  a_hi: assert property (p_hi) else $error("high bits");
  property p_idl; !io_rd |=> io_rdata == 8'h00; endproperty
  a_idl: assert property (p_idl) else $error("idle data");
endmodule // eba_chk
bind eba_port eba_chk #(.T_ATOMIC_CYC(T_ATOMIC_CYC), .T_SPLIT_CYC(T_SPLIT_CYC)) u_chk (.*);

// >>> tb/eba_cpu_model.sv
// CPU-side model issuing I/O register cycles
`timescale 1ns/100ps
`include "eba_map.vh"
module eba_cpu_model #(
  parameter DEPTH = 512
) (
  input wire clk,
  input wire cpu_stall,
  input wire [7:0] io_rdata,
  output reg [5:0] io_addr,
  output reg io_wr,
  output reg io_rd,
  output reg [7:0] io_wdata
);
  initial {io_addr, io_wr, io_rd, io_wdata} = 16'h0000;
  task io_cyc(input w, input [5:0] a, input [7:0] d, output [7:0] q);
    begin
      @(posedge clk);
      #1;
      // Halted core issues nothing
      while (cpu_stall) #5;
      {io_addr, io_wr, io_rd, io_wdata} = {a, w, !w, d};
      @(posedge clk);
      #1;
      q = io_rdata;
      {io_wr, io_rd, io_wdata} = {2'b00, ~d};
    end
  endtask
  task ee_acc(input rd, input [8:0] a, input [7:0] d, input [1:0] m, output [7:0] q);
    begin
      io_cyc(1'b1, `EBA_OFS_ADDR_HI, {7'h0, a[8] && DEPTH != 256}, q);
      io_cyc(1'b1, `EBA_OFS_ADDR_LO, a[7:0], q);
      if (rd) begin
        io_cyc(1'b1, `EBA_OFS_CTRL, 8'h01, q);
        io_cyc(1'b0, `EBA_OFS_DATA, 8'h00, q);
      end else begin
        io_cyc(1'b1, `EBA_OFS_DATA, d, q);
        io_cyc(1'b1, `EBA_OFS_CTRL, {2'h0, m, 4'h4}, q);
        io_cyc(1'b1, `EBA_OFS_CTRL, {2'h0, m, 4'h2}, q);
      end
    end
  endtask
endmodule // eba_cpu_model

// >>> tb/eba_port_tb.sv
// Self-checking bench for the EEPROM byte access port
`timescale 1ns/100ps
`include "eba_map.vh"
module eba_port_tb;
  reg clk;
  reg sys_rst;
  wire [5:0] io_addr;
  wire io_wr, io_rd, cpu_stall, write_busy;
  wire [7:0] io_wdata, io_rdata;
  reg [31:0] seed = 32'hf3ecfa75;
  integer bad_count = 0, check_count = 0, cyc = 0, i, m;
  reg [7:0] q, ev;
  reg [8:0] a;
  eba_port #(.DEPTH(512), .T_ATOMIC_CYC(20), .T_SPLIT_CYC(10)) u_dut (.clk(clk),
    .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .cpu_stall(cpu_stall), .write_busy(write_busy));
  eba_cpu_model #(.DEPTH(512)) u_cpu (.clk(clk), .cpu_stall(cpu_stall), .io_rdata(io_rdata),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Erase gives all ones, a plain write can only clear bits
  function [7:0] prog(input [7:0] o, input [1:0] m, input [7:0] d);
    prog = m == 2'h0 ? d : m == 2'h1 ? 8'hff : m == 2'h2 ? (o & d) : o;
  endfunction
  task cmp(input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  task complete_run;
    begin
      if (bad_count == 0 && check_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task wait_idle;
    begin
      repeat (4) @(posedge clk);
      repeat (60) if (write_busy) @(posedge clk);
      cmp(8'h00, {7'h0, write_busy});
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  initial begin
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    u_cpu.io_cyc(1'b0, `EBA_OFS_ADDR_HI, 8'h00, q);
    cmp(8'h00, q);
    for (i = 0; i < 6; i = i + 1) begin
      seed = lfsr(seed);
      a = i == 0 ? 9'h1ff : i == 1 ? 9'h000 : seed[8:0];
      ev = seed[16:9];
      u_cpu.ee_acc(1'b0, a, ev, 2'h0, q);
      wait_idle;
      for (m = 1; m < 4; m = m + 1) begin
        seed = lfsr(seed);
        u_cpu.ee_acc(1'b0, a, seed[7:0], m[1:0], q);
        wait_idle;
        ev = prog(ev, m[1:0], seed[7:0]);
        u_cpu.ee_acc(1'b1, a, 8'h00, 2'h0, q);
        cmp(ev, q);
      end
    end
    u_cpu.io_cyc(1'b1, `EBA_OFS_CTRL, 8'h04, q);
    repeat (4) @(posedge clk);
    u_cpu.io_cyc(1'b1, `EBA_OFS_CTRL, 8'h02, q);
    u_cpu.io_cyc(1'b1, `EBA_OFS_CTRL, 8'h02, q);
    u_cpu.ee_acc(1'b1, a, 8'h00, 2'h0, q);
    cmp(ev, q);
    seed = lfsr(seed);
    u_cpu.ee_acc(1'b0, a, seed[7:0], 2'h0, q);
    u_cpu.io_cyc(1'b1, `EBA_OFS_ADDR_LO, ~a[7:0], q);
    u_cpu.io_cyc(1'b1, `EBA_OFS_CTRL, 8'h01, q);
    u_cpu.io_cyc(1'b0, `EBA_OFS_DATA, 8'h00, q);
    cmp(seed[7:0], q);
    wait_idle;
    u_cpu.io_cyc(1'b0, `EBA_OFS_ADDR_LO, 8'h00, q);
    cmp(a[7:0], q);
    u_cpu.io_cyc(1'b1, `EBA_OFS_ADDR_HI, 8'hff, q);
    u_cpu.io_cyc(1'b0, `EBA_OFS_ADDR_HI, 8'h00, q);
    cmp(8'h01, q);
    u_cpu.io_cyc(1'b0, 6'h3f, 8'h00, q);
    cmp(8'h00, q);
    complete_run;
  end
endmodule // eba_port_tb
